// ===== logic/card_ctrl_pkg.sv
package card_ctrl_pkg;
  // Register offsets
  localparam logic [7:0] CARD_CTRL_OFFSET = 8'h91;
  localparam logic [7:0] DEV_CTRL_OFFSET = 8'h92;
  // Reset values
  localparam logic [7:0] CARD_CTRL_RESET = 8'h00;
  localparam logic [7:0] DEV_CTRL_RESET = 8'h66;
  // Card control fields
  localparam int RING_EN_BIT = 7;
  localparam int VIDEO_BIT = 6;
  localparam int AUDIO_BIT = 2;
  localparam int SPKR_BIT = 1;
  localparam int IRQ_FLAG_BIT = 0;
  // Device control fields
  localparam int LV_CAP_BIT = 6;
  localparam int DIAG5_BIT = 5;
  localparam int TEST_BIT = 3;
  localparam int MODE_HI_BIT = 2;
  localparam int MODE_LO_BIT = 1;
  localparam int NAND_BIT = 0;
  // Writable masks; other bits are reserved
  localparam logic [7:0] CARD_CTRL_WMASK = 8'hc7;
  localparam logic [7:0] DEV_CTRL_WMASK = 8'h6f;
  // Irq mux field code that selects the ring indicate output
  localparam logic [3:0] MUX_SEL_RING = 4'h2;
  // Function numbers
  localparam logic FUNC0 = 1'b0;
  localparam logic FUNC1 = 1'b1;

  typedef enum logic [1:0] {
    MODE_PAR_PCI = 2'b00,
    MODE_PAR_IRQ_PCI = 2'b01,
    MODE_SER_IRQ_PAR_PCI = 2'b10,
    MODE_SER_ALL = 2'b11
  } irq_mode_t;

  typedef struct packed {
    logic video;
    logic audio;
    logic spkr;
    logic irq_flag;
  } socket_ctrl_t;

  typedef struct packed {
    logic ring_en;
    logic lv_cap;
    logic diag5;
    logic test;
    irq_mode_t mode;
    logic nand_en;
  } global_ctrl_t;

  typedef struct packed {
    socket_ctrl_t [1:0] sock;
    global_ctrl_t glob;
    logic [7:0] rdata;
  } regs_state_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic func;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfg_req_t;
endpackage

// ===== logic/card_device_control_regs.sv
`timescale 1ns/1ns
// Summary of operation
// RQ1 - Ring enable gates all ring indicate routing
// RQ2 - Video bit tristates that socket's video pins
// RQ3 - Video bit aliases per-function multimedia enable
// RQ4 - Audio bit routes socket audio to mux
// RQ5 - Both audio bits set: function 0 wins
// RQ6 - Speaker output is XOR of enabled sockets
// RQ7 - Speaker pin driven only when enabled
// RQ8 - Card interrupt sets per-socket flag
// RQ9 - Writing one clears flag, zero keeps
// RQ10 - Reserved bits read zero, ignore writes
// RQ11 - Device bit 6 forces 3-V capability
// RQ12 - Device bit 5 diagnostic, resets one
// RQ13 - Test bit shortens card interrogation counter
// RQ14 - Two-bit field selects interrupt signalling mode
// RQ15 - Bit 0 enables input-pin NAND tree
// RQ16 - Global bits shared by both functions
// RQ17 - Mux code 0010 drives ring signal
// RQ18 - Socket bits kept per function
module card_device_control_regs (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Configuration access
  input wire card_ctrl_pkg::cfg_req_t i_cfg,
  output logic [7:0] o_rdata,
  // Multimedia control aliases
  input wire logic i_mm_video_wr,
  input wire logic [1:0] i_mm_video_wdata,
  output logic [1:0] o_video_port_enable,
  // Card events and signals
  input wire logic [1:0] i_card_func_irq,
  input wire logic [1:0] i_card_audio,
  input wire logic [1:0] i_card_spkr,
  input wire logic i_ring_indicate,
  input wire logic i_ring_pin_select,
  input wire logic [3:0] i_irq_mux3_sel,
  input wire logic [3:0] i_irq_mux4_sel,
  // Pin outputs
  output logic o_ring_pme_pin,
  output logic o_ring_pme_oe,
  output logic [4:0] o_irq_mux_pin,
  output logic [4:0] o_irq_mux_oe,
  output logic o_speaker_output_pin,
  output logic o_speaker_oe,
  output logic [1:0] o_video_tristate,
  // Global controls
  output logic o_low_voltage_capable,
  output logic o_diag_bit_five,
  output logic o_short_interrogation,
  output card_ctrl_pkg::irq_mode_t o_irq_signal_mode,
  output logic o_nand_tree_enable
);
  card_ctrl_pkg::regs_state_t st_ff;
  card_ctrl_pkg::regs_state_t nxt_st;
  logic [7:0] card_view;
  logic [7:0] dev_view;
  logic ring_ok;
  logic sel_card;
  logic sel_dev;

  always_comb begin
    sel_card = i_cfg.addr == card_ctrl_pkg::CARD_CTRL_OFFSET;
    sel_dev = i_cfg.addr == card_ctrl_pkg::DEV_CTRL_OFFSET;
    card_view = 8'h00; // [RQ10]
    card_view[card_ctrl_pkg::RING_EN_BIT] = st_ff.glob.ring_en; // [RQ16]
    card_view[card_ctrl_pkg::VIDEO_BIT] = st_ff.sock[i_cfg.func].video; // [RQ3] [RQ18]
    card_view[card_ctrl_pkg::AUDIO_BIT] = st_ff.sock[i_cfg.func].audio; // [RQ18]
    card_view[card_ctrl_pkg::SPKR_BIT] = st_ff.sock[i_cfg.func].spkr;
    card_view[card_ctrl_pkg::IRQ_FLAG_BIT] = st_ff.sock[i_cfg.func].irq_flag;
    dev_view = 8'h00; // [RQ10]
    dev_view[card_ctrl_pkg::LV_CAP_BIT] = st_ff.glob.lv_cap;
    dev_view[card_ctrl_pkg::DIAG5_BIT] = st_ff.glob.diag5;
    dev_view[card_ctrl_pkg::TEST_BIT] = st_ff.glob.test;
    dev_view[card_ctrl_pkg::MODE_HI_BIT:card_ctrl_pkg::MODE_LO_BIT] = st_ff.glob.mode;
    dev_view[card_ctrl_pkg::NAND_BIT] = st_ff.glob.nand_en;
  end

  always_comb begin
    nxt_st = st_ff;
    if (i_mm_video_wr) begin
      nxt_st.sock[0].video = i_mm_video_wdata[0]; // [RQ3]
      nxt_st.sock[1].video = i_mm_video_wdata[1]; // [RQ3]
    end
    if (i_cfg.req && i_cfg.wr && sel_card) begin
      nxt_st.glob.ring_en = i_cfg.wdata[card_ctrl_pkg::RING_EN_BIT]; // [RQ16]
      nxt_st.sock[i_cfg.func].video = i_cfg.wdata[card_ctrl_pkg::VIDEO_BIT]; // [RQ18]
      nxt_st.sock[i_cfg.func].audio = i_cfg.wdata[card_ctrl_pkg::AUDIO_BIT];
      nxt_st.sock[i_cfg.func].spkr = i_cfg.wdata[card_ctrl_pkg::SPKR_BIT];
      if (i_cfg.wdata[card_ctrl_pkg::IRQ_FLAG_BIT]) begin
        nxt_st.sock[i_cfg.func].irq_flag = 1'b0; // [RQ9]
      end
    end else if (i_cfg.req && i_cfg.wr && sel_dev) begin
      nxt_st.glob.lv_cap = i_cfg.wdata[card_ctrl_pkg::LV_CAP_BIT]; // [RQ11]
      nxt_st.glob.diag5 = i_cfg.wdata[card_ctrl_pkg::DIAG5_BIT]; // [RQ12]
      nxt_st.glob.test = i_cfg.wdata[card_ctrl_pkg::TEST_BIT]; // [RQ13]
      nxt_st.glob.mode = card_ctrl_pkg::irq_mode_t'(
        i_cfg.wdata[card_ctrl_pkg::MODE_HI_BIT:card_ctrl_pkg::MODE_LO_BIT]); // [RQ14]
      nxt_st.glob.nand_en = i_cfg.wdata[card_ctrl_pkg::NAND_BIT]; // [RQ15]
    end
    // Set wins over a same-cycle clear
    for (int s = 0; s < 2; s++) begin
      if (i_card_func_irq[s]) begin
        nxt_st.sock[s].irq_flag = 1'b1; // [RQ8]
      end
    end
    if (i_cfg.req && !i_cfg.wr && sel_card) begin
      nxt_st.rdata = card_view;
    end else if (i_cfg.req && !i_cfg.wr && sel_dev) begin
      nxt_st.rdata = dev_view;
    end else if (i_cfg.req && !i_cfg.wr) begin
      nxt_st.rdata = 8'h00;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_ff.sock <= '0;
      st_ff.glob.ring_en <= card_ctrl_pkg::CARD_CTRL_RESET[card_ctrl_pkg::RING_EN_BIT];
      st_ff.glob.lv_cap <= card_ctrl_pkg::DEV_CTRL_RESET[card_ctrl_pkg::LV_CAP_BIT]; // [RQ11]
      st_ff.glob.diag5 <= card_ctrl_pkg::DEV_CTRL_RESET[card_ctrl_pkg::DIAG5_BIT]; // [RQ12]
      st_ff.glob.test <= card_ctrl_pkg::DEV_CTRL_RESET[card_ctrl_pkg::TEST_BIT];
      st_ff.glob.mode <= card_ctrl_pkg::MODE_SER_ALL; // [RQ14]
      st_ff.glob.nand_en <= card_ctrl_pkg::DEV_CTRL_RESET[card_ctrl_pkg::NAND_BIT];
      st_ff.rdata <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    ring_ok = st_ff.glob.ring_en; // [RQ1]
    o_rdata = st_ff.rdata;
    o_video_port_enable = {st_ff.sock[1].video, st_ff.sock[0].video}; // [RQ3]
    o_video_tristate = {st_ff.sock[1].video, st_ff.sock[0].video}; // [RQ2]
    o_ring_pme_pin = i_ring_indicate;
    o_ring_pme_oe = ring_ok && (i_ring_pin_select == 1'b0); // [RQ1]
    o_irq_mux_pin = 5'h00;
    o_irq_mux_oe = 5'h00;
    if (st_ff.sock[0].audio) begin
      o_irq_mux_pin[0] = i_card_audio[0]; // [RQ4] [RQ5]
      o_irq_mux_oe[0] = 1'b1;
    end else if (st_ff.sock[1].audio) begin
      o_irq_mux_pin[1] = i_card_audio[1]; // [RQ4]
      o_irq_mux_oe[1] = 1'b1;
    end
    if (ring_ok && i_irq_mux3_sel == card_ctrl_pkg::MUX_SEL_RING) begin
      o_irq_mux_pin[3] = i_ring_indicate; // [RQ17]
      o_irq_mux_oe[3] = 1'b1;
    end
    if (ring_ok && i_irq_mux4_sel == card_ctrl_pkg::MUX_SEL_RING) begin
      o_irq_mux_pin[4] = i_ring_indicate; // [RQ17]
      o_irq_mux_oe[4] = 1'b1;
    end
    o_speaker_output_pin = (st_ff.sock[0].spkr & i_card_spkr[0])
      ^ (st_ff.sock[1].spkr & i_card_spkr[1]); // [RQ6]
    o_speaker_oe = st_ff.sock[0].spkr | st_ff.sock[1].spkr; // [RQ7]
    o_low_voltage_capable = st_ff.glob.lv_cap;
    o_diag_bit_five = st_ff.glob.diag5;
    o_short_interrogation = st_ff.glob.test; // [RQ13]
    o_irq_signal_mode = st_ff.glob.mode;
    o_nand_tree_enable = st_ff.glob.nand_en; // [RQ15]
  end
endmodule // card_device_control_regs

// ===== dv/card_device_control_regs_assertions.sv
`timescale 1ns/1ns
module card_device_control_regs_assertions (
  // Clock, reset and access
  input wire logic i_clock,
  input wire logic i_rst,
  input wire card_ctrl_pkg::cfg_req_t i_cfg,
  input wire logic [7:0] o_rdata,
  // Pins and state
  input wire logic [1:0] i_card_audio,
  input wire logic i_ring_indicate,
  input wire logic i_ring_pin_select,
  input wire logic [3:0] i_irq_mux3_sel,
  input wire logic o_ring_pme_pin,
  input wire logic o_ring_pme_oe,
  input wire logic [4:0] o_irq_mux_pin,
  input wire logic [4:0] o_irq_mux_oe,
  input wire logic o_speaker_oe,
  input wire logic [1:0] o_video_port_enable,
  input wire logic [1:0] o_video_tristate,
  input wire logic o_low_voltage_capable,
  input wire card_ctrl_pkg::irq_mode_t o_irq_signal_mode
);
  wire rd = i_cfg.req && !i_cfg.wr;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_unmapped_read: assert property (rd && !(i_cfg.addr inside {8'h91, 8'h92}) |=> o_rdata == 8'h00)
    else $error("Unmapped read not zero");
  a_card_read: assert property (rd && i_cfg.addr == 8'h91 |=>
    o_rdata[5:3] == 3'h0 && o_rdata[6] == $past(o_video_port_enable[i_cfg.func]))
    else $error("Card control read wrong");
  a_dev_read: assert property (rd && i_cfg.addr == 8'h92 |=>
    !o_rdata[7] && !o_rdata[4] && o_rdata[6] == $past(o_low_voltage_capable)
    && o_rdata[2:1] == $past(o_irq_signal_mode)) else $error("Device control read wrong");
  a_video_tristate: assert property (o_video_tristate == o_video_port_enable)
    else $error("Video tristate mismatch");
  a_audio_mux: assert property (o_irq_mux_oe[0] |-> o_irq_mux_pin[0] == i_card_audio[0])
    else $error("Audio on mux pin 0 wrong");
  a_audio_single: assert property (!(o_irq_mux_oe[0] && o_irq_mux_oe[1]))
    else $error("Both audio routes driven");
  a_ring_pme: assert property (o_ring_pme_oe |-> !i_ring_pin_select && o_ring_pme_pin == i_ring_indicate)
    else $error("Ring pin routing wrong");
  a_ring_mux: assert property (o_irq_mux_oe[3] |-> i_irq_mux3_sel == 4'h2 && o_irq_mux_pin[3] == i_ring_indicate)
    else $error("Ring on mux pin 3 wrong");
  a_ring_shared: assert property (o_ring_pme_oe && i_irq_mux3_sel == 4'h2 |-> o_irq_mux_oe[3])
    else $error("Ring enables disagree");
  c_dev_read: cover property (rd && i_cfg.addr == 8'h92);
  c_audio1: cover property (o_irq_mux_oe[1]);
  c_speaker: cover property (o_speaker_oe);
endmodule // card_device_control_regs_assertions

// ===== dv/card_socket_model.sv
`timescale 1ns/1ns
module card_socket_model (
  // Clock and control
  input wire logic i_clock,
  input wire logic [1:0] i_irq_req,
  // Card signals
  output logic [1:0] o_card_func_irq,
  output logic [1:0] o_card_audio,
  output logic [1:0] o_card_spkr,
  output logic o_ring_indicate
);
  logic [3:0] cnt_ff = 4'h0;
  always_ff @(posedge i_clock) cnt_ff <= cnt_ff + 4'h1;
  // Audio lines change every cycle; speaker and ring lines follow the higher counter bits
  assign {o_ring_indicate, o_card_spkr, o_card_audio[0]} = cnt_ff;
  assign o_card_audio[1] = ~cnt_ff[0];
  assign o_card_func_irq = i_irq_req;
endmodule // card_socket_model

// ===== dv/tb_card_device_control_regs.sv
`timescale 1ns/1ns
module tb_card_device_control_regs;
  logic i_clock = 1'b0, i_rst = 1'b1, i_mm_video_wr = 1'b0, i_ring_pin_select = 1'b0;
  logic i_ring_indicate, o_ring_pme_pin, o_ring_pme_oe, o_speaker_output_pin, o_speaker_oe;
  logic o_low_voltage_capable, o_diag_bit_five, o_short_interrogation, o_nand_tree_enable;
  card_ctrl_pkg::cfg_req_t i_cfg = '0;
  card_ctrl_pkg::irq_mode_t o_irq_signal_mode;
  logic [1:0] i_mm_video_wdata = 2'h0, irq = 2'h0, i_card_func_irq, i_card_audio, i_card_spkr;
  logic [1:0] o_video_port_enable, o_video_tristate;
  logic [3:0] i_irq_mux3_sel = 4'h2, i_irq_mux4_sel = 4'h2;
  logic [4:0] o_irq_mux_pin, o_irq_mux_oe;
  logic [7:0] o_rdata;
  int n_mismatch = 0, n_checks = 0;
  always #10 i_clock = ~i_clock;
  card_device_control_regs card_device_control_regs_inst (.*);
  card_socket_model card_socket_model_inst (.i_clock, .i_irq_req(irq),
    .o_card_func_irq(i_card_func_irq), .o_card_audio(i_card_audio),
    .o_card_spkr(i_card_spkr), .o_ring_indicate(i_ring_indicate));
  task automatic acc(input logic w, f, input logic [7:0] a, d);
    @(posedge i_clock) i_cfg <= '{1'b1, w, f, a, d};
    @(posedge i_clock) i_cfg.req <= 1'b0;
    @(negedge i_clock);
  endtask
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic f, input logic [7:0] a, exp);
    acc(1'b0, f, a, 8'h00);
    chk(o_rdata, exp);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000 n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    rdc(1'b0, 8'h92, 8'h66);
    chk({o_low_voltage_capable, o_diag_bit_five, o_irq_signal_mode, 4'h0}, 8'hf0);
    acc(1'b1, 1'b1, 8'h92, 8'hff);
    rdc(1'b0, 8'h92, 8'h6f);
    chk({o_short_interrogation, o_nand_tree_enable, 6'h0}, 8'hc0);
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, 1'b0, 8'h92, 8'h60 | 8'(m << 1));
      rdc(1'b0, 8'h92, 8'h60 | 8'(m << 1));
      chk({6'h0, o_irq_signal_mode}, 8'(m));
    end
    acc(1'b1, 1'b0, 8'h93, 8'hff);
    rdc(1'b0, 8'h93, 8'h00);
    acc(1'b1, 1'b0, 8'h91, 8'hff);
    rdc(1'b0, 8'h91, 8'hc6);
    rdc(1'b1, 8'h91, 8'h80);
    chk({4'h0, o_video_port_enable, o_video_tristate}, 8'h05);
    @(posedge i_clock) {i_mm_video_wr, i_mm_video_wdata} <= 3'h6;
    @(posedge i_clock) i_mm_video_wr <= 1'b0;
    rdc(1'b1, 8'h91, 8'hc0);
    rdc(1'b0, 8'h91, 8'h86);
    acc(1'b1, 1'b1, 8'h91, 8'hc4);
    chk({o_irq_mux_oe[1:0], 5'h0, o_irq_mux_pin[0]}, {7'h20, i_card_audio[0]});
    acc(1'b1, 1'b0, 8'h91, 8'h80);
    chk({o_irq_mux_oe[1:0], o_speaker_oe, 4'h0, o_irq_mux_pin[1]}, {7'h40, i_card_audio[1]});
    acc(1'b1, 1'b1, 8'h91, 8'hc6);
    chk({6'h0, o_speaker_oe, o_speaker_output_pin}, {7'h1, i_card_spkr[1]});
    acc(1'b1, 1'b0, 8'h91, 8'h82);
    chk({6'h0, o_speaker_oe, o_speaker_output_pin}, {7'h1, ^i_card_spkr});
    chk({o_ring_pme_oe, o_ring_pme_pin, o_irq_mux_oe[3], o_irq_mux_pin[3], 4'h0},
      {1'b1, i_ring_indicate, 1'b1, i_ring_indicate, 4'h0});
    acc(1'b1, 1'b0, 8'h91, 8'h02);
    chk({6'h0, o_ring_pme_oe, o_irq_mux_oe[3]}, 8'h00);
    @(posedge i_clock) irq <= 2'h2;
    @(posedge i_clock) irq <= 2'h0;
    rdc(1'b1, 8'h91, 8'h47);
    rdc(1'b0, 8'h91, 8'h02);
    acc(1'b1, 1'b1, 8'h91, 8'h46);
    rdc(1'b1, 8'h91, 8'h47);
    acc(1'b1, 1'b1, 8'h91, 8'h47);
    rdc(1'b1, 8'h91, 8'h46);
    // Reset again in mid-run
    @(posedge i_clock) i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    rdc(1'b0, 8'h92, 8'h66);
    rdc(1'b1, 8'h91, 8'h00);
    report_and_stop();
  end
endmodule // tb_card_device_control_regs
bind card_device_control_regs card_device_control_regs_assertions card_device_control_regs_assertions_inst (.*);
